// file: hdl/line_term_pkg.sv
// constants for the usb line termination control block
// assumes a plain single-word register port on mclk_i
package line_term_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned CTRL_W = 8;
	// -----------------------------------------------------------------
	// register map
	// -----------------------------------------------------------------
	localparam logic [3:0] TERM_CTRL_OFF = 4'h0;
	localparam logic [3:0] TERM_STAT_OFF = 4'h4;
	localparam logic [7:0] TERM_CTRL_RESET = 8'h00;
	// -----------------------------------------------------------------
	// field positions
	// -----------------------------------------------------------------
	localparam int unsigned DPLUS_PULLUP_BIT = 7;
	localparam int unsigned DMINUS_PULLUP_BIT = 6;
	localparam int unsigned DPLUS_PULLDOWN_BIT = 5;
	localparam int unsigned DMINUS_PULLDOWN_BIT = 4;
	localparam int unsigned VBUS_POWER_BIT = 3;
	localparam int unsigned SW_SELECT_BIT = 2;
	localparam int unsigned VBUS_CHARGE_BIT = 1;
	localparam int unsigned VBUS_DISCHARGE_BIT = 0;
	typedef enum logic [1:0] {
		OWNER_HW = 2'b01,
		OWNER_SW = 2'b10
	} owner_t;
endpackage : line_term_pkg

// file: hdl/term_bus_if.sv
// carrier between the register file and the termination mux
// assumes both ends on mclk_i
`timescale 1ns/1ps
interface term_bus_if;
	logic [3:0] sw_res;
	logic [3:0] hw_res;
	logic sw_sel;
	logic [3:0] res_en;
	modport ctrl(output sw_res, output hw_res, output sw_sel, input res_en);
	modport mux(input sw_res, input hw_res, input sw_sel, output res_en);
endinterface : term_bus_if

// file: hdl/term_mux.sv
// resistor enable selection between software and usb hardware
// assumes registered inputs from the control register
`timescale 1ns/1ps
module term_mux (
	input wire logic mclk_i,
	input wire logic rstn_i,
	term_bus_if.mux bus
);
	import line_term_pkg::*;
	logic [3:0] res_en_q;
	logic [3:0] res_en_d;
	// -----------------------------------------------------------------
	// selection
	// -----------------------------------------------------------------
	// owner select
	assign res_en_d = bus.sw_sel ? bus.sw_res : bus.hw_res;
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			res_en_q <= 4'h0;
		end else begin
			res_en_q <= res_en_d;
		end
	end
	assign bus.res_en = res_en_q;
	a_mux_owner: assert property (@(posedge mclk_i) disable iff (!rstn_i) 1'b1 ##1
		bus.res_en == ($past(bus.sw_sel) ? $past(bus.sw_res) : $past(bus.hw_res)))
		else $error("resistor enables do not follow selected owner");
endmodule : term_mux

// file: hdl/usb_line_termination_control.sv
// usb line termination control register and its line controls
// assumes usb hardware requests arrive from outside on another domain
//
// Behaviour
// - bits 31 to 8 read as zero and ignore writes.
// - bit 7 enables the d+ pull-up.
// - bit 6 enables the d- pull-up.
// - bit 5 enables the d+ pull-down.
// - bit 4 enables the d- pull-down.
// - bit 3 powers vbus.
// - bit 2 gives the four resistor enables to software, else to usb hardware.
// - bit 1 charges vbus through a pull-up.
// - bit 0 discharges vbus through a pull-down.
`timescale 1ns/1ps
module usb_line_termination_control (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic [line_term_pkg::ADDR_W-1:0] addr_i,
	input wire logic [line_term_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [line_term_pkg::DATA_W-1:0] rdata_o,
	input wire logic [3:0] hw_res_req_i,
	output logic dplus_pullup_enable_o,
	output logic dminus_pullup_enable_o,
	output logic dplus_pulldown_enable_o,
	output logic dminus_pulldown_enable_o,
	output logic vbus_power_enable_o,
	output logic vbus_charge_enable_o,
	output logic vbus_discharge_enable_o
);
	import line_term_pkg::*;
	logic [CTRL_W-1:0] ctrl_q;
	logic [CTRL_W-1:0] ctrl_d;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;
	logic [3:0] hw_meta_q;
	logic [3:0] hw_sync_q;
	owner_t owner;
	wire ctrl_hit;
	wire stat_hit;
	wire ctrl_wr;
	logic [DATA_W-1:0] ctrl_word;
	logic [DATA_W-1:0] stat_word;
	term_bus_if tb ();
	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	// control byte widened to the bus word; bits above it always read zero
	function automatic logic [DATA_W-1:0] widen_ctrl(input logic [CTRL_W-1:0] c);
		return {{(DATA_W-CTRL_W){1'h0}}, c};
	endfunction : widen_ctrl
	// resistor requests in {d+ up, d- up, d+ down, d- down} order
	function automatic logic [3:0] res_field(input logic [CTRL_W-1:0] c);
		return {c[DPLUS_PULLUP_BIT], c[DMINUS_PULLUP_BIT],
			c[DPLUS_PULLDOWN_BIT], c[DMINUS_PULLDOWN_BIT]};
	endfunction : res_field
	// -----------------------------------------------------------------
	// hardware request synchroniser
	// -----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hw_meta_q <= 4'h0;
			hw_sync_q <= 4'h0;
		end else begin
			hw_meta_q <= hw_res_req_i;
			hw_sync_q <= hw_meta_q;
		end
	end
	// -----------------------------------------------------------------
	// register decode
	// -----------------------------------------------------------------
	assign ctrl_hit = (addr_i == TERM_CTRL_OFF);
	assign stat_hit = (addr_i == TERM_STAT_OFF);
	assign ctrl_wr = wr_i && ctrl_hit;
	assign ctrl_d = ctrl_wr ? wdata_i[CTRL_W-1:0] : ctrl_q;
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl_q <= TERM_CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end
	// status word shows the live resistor enables and owner
	assign ctrl_word = widen_ctrl(ctrl_q);
	assign stat_word = {27'h000_0000, ctrl_q[SW_SELECT_BIT], tb.res_en};
	assign rdata_d = !rd_i ? 32'h0000_0000 :
		ctrl_hit ? ctrl_word :
		stat_hit ? stat_word : 32'h0000_0000;
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end
	assign rdata_o = rdata_q;
	// -----------------------------------------------------------------
	// termination ownership
	// -----------------------------------------------------------------
	// owner choice
	assign owner = ctrl_q[SW_SELECT_BIT] ? OWNER_SW : OWNER_HW;
	assign tb.sw_sel = (owner == OWNER_SW);
	assign tb.sw_res = res_field(ctrl_q);
	assign tb.hw_res = hw_sync_q;
	// mux adds one cycle so a hand-over never glitches the resistors
	term_mux u_mux (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.bus(tb)
	);
	// -----------------------------------------------------------------
	// line outputs
	// -----------------------------------------------------------------
	// d+ pull-up
	assign dplus_pullup_enable_o = tb.res_en[3];
	assign dminus_pullup_enable_o = tb.res_en[2];
	assign dplus_pulldown_enable_o = tb.res_en[1];
	assign dminus_pulldown_enable_o = tb.res_en[0];
	assign vbus_power_enable_o = ctrl_q[VBUS_POWER_BIT];
	assign vbus_charge_enable_o = ctrl_q[VBUS_CHARGE_BIT];
	assign vbus_discharge_enable_o = ctrl_q[VBUS_DISCHARGE_BIT];
	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	// pin groups, so a wiring slip behind the flops is caught too
	logic [3:0] res_out;
	logic [2:0] vbus_out;
	assign res_out = {dplus_pullup_enable_o, dminus_pullup_enable_o,
		dplus_pulldown_enable_o, dminus_pulldown_enable_o};
	assign vbus_out = {vbus_power_enable_o, vbus_charge_enable_o, vbus_discharge_enable_o};
	a_upper_read_zero: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		rd_i |=> rdata_o[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	a_idle_read_zero: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!rd_i |=> rdata_o == 32'h0000_0000)
		else $error("read data not zero outside a read");
	a_ctrl_read_back: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		rd_i && ctrl_hit |=> rdata_o == widen_ctrl($past(ctrl_q)))
		else $error("control read does not return the stored byte");
	a_unmapped_read: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		rd_i && !ctrl_hit && !stat_hit |=> rdata_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_ctrl_write_low: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ctrl_wr |=> ctrl_q == $past(wdata_i[CTRL_W-1:0]))
		else $error("control write not stored");
	a_ctrl_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!ctrl_wr |=> $stable(ctrl_q))
		else $error("control changed without a control write");
	a_dplus_pullup_sw: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ctrl_wr && wdata_i[2] |-> ##2 dplus_pullup_enable_o == $past(wdata_i[7], 2))
		else $error("d+ pull-up not from software bit");
	a_dminus_pullup_sw: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ctrl_wr && wdata_i[2] |-> ##2 dminus_pullup_enable_o == $past(wdata_i[6], 2))
		else $error("d- pull-up not from software bit");
	a_dplus_pulldn_sw: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ctrl_wr && wdata_i[2] |-> ##2 dplus_pulldown_enable_o == $past(wdata_i[5], 2))
		else $error("d+ pull-down not from software bit");
	a_dminus_pulldn_sw: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ctrl_wr && wdata_i[2] |-> ##2 dminus_pulldown_enable_o == $past(wdata_i[4], 2))
		else $error("d- pull-down not from software bit");
	a_vbus_power_on: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ctrl_wr |=> vbus_power_enable_o == $past(wdata_i[3]))
		else $error("vbus power not following write");
	a_vbus_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!ctrl_wr |=> $stable(vbus_out))
		else $error("vbus controls changed without a control write");
	a_sw_owner_lines: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ctrl_q[SW_SELECT_BIT] |=> res_out == $past(res_field(ctrl_q)))
		else $error("software owner not driving resistors");
	a_hw_owner_path: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!ctrl_q[SW_SELECT_BIT] |=> res_out == $past(hw_sync_q))
		else $error("hardware owner not driving resistors");
	a_stat_read_back: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		rd_i && stat_hit |=>
		rdata_o == {27'h000_0000, $past(ctrl_q[SW_SELECT_BIT]), $past(tb.res_en)})
		else $error("status read does not show owner and enables");
	a_vbus_charge_on: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ctrl_wr |=> vbus_charge_enable_o == $past(wdata_i[1]))
		else $error("vbus charge not following write");
	a_vbus_discharge_on: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		ctrl_wr |=> vbus_discharge_enable_o == $past(wdata_i[0]))
		else $error("vbus discharge not following write");
	a_reset_clear_ctrl: assert property (@(posedge mclk_i)
		$rose(rstn_i) |-> ctrl_q == 8'h00)
		else $error("control not cleared by reset");
	a_lines_off_reset: assert property (@(posedge mclk_i)
		!rstn_i |=> {res_out, vbus_out} == 7'h00)
		else $error("line controls not off during reset");
	a_read_zero_reset: assert property (@(posedge mclk_i)
		!rstn_i |=> ctrl_q == TERM_CTRL_RESET && rdata_o == 32'h0000_0000)
		else $error("register not cleared during reset");
endmodule : usb_line_termination_control

// file: sim/usb_hw_model.sv
// far-side usb hardware: holds resistor requests as levels
// assumes the bench hands it the next request pattern
`timescale 1ns/1ps
module usb_hw_model (
	input wire logic mclk_i,
	input wire logic [3:0] next_i,
	output logic [3:0] hw_res_req_o
);
	initial hw_res_req_o = 4'h0;
	always @(posedge mclk_i) begin
		hw_res_req_o <= next_i;
	end
endmodule : usb_hw_model

// file: sim/tb_top.sv
// self-checking bench for the line termination control block
// assumes one clock and the plain register port
`timescale 1ns/1ps
module tb_top;
	import line_term_pkg::*;
	logic mclk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [3:0] hw_next = 4'h0;
	logic [3:0] hw_res_req_i;
	logic [31:0] wdata_i = 32'h0;
	logic [31:0] rdata_o;
	logic [31:0] w;
	logic [31:0] r;
	wire [6:0] lines;
	logic [6:0] exp_l;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	always #20 mclk_i = ~mclk_i;
	usb_hw_model usb_hw_model_i (.mclk_i(mclk_i), .next_i(hw_next), .hw_res_req_o(hw_res_req_i));
	usb_line_termination_control usb_line_termination_control_i (
		.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .hw_res_req_i(hw_res_req_i),
		.dplus_pullup_enable_o(lines[6]), .dminus_pullup_enable_o(lines[5]),
		.dplus_pulldown_enable_o(lines[4]), .dminus_pulldown_enable_o(lines[3]),
		.vbus_power_enable_o(lines[2]), .vbus_charge_enable_o(lines[1]),
		.vbus_discharge_enable_o(lines[0]));
	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	function automatic logic [6:0] exp_lines(input logic [7:0] c, input logic [3:0] hw);
		return {(c[2] ? c[7:4] : hw), c[3], c[1], c[0]};
	endfunction : exp_lines
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd
	// covers 2 sync flops, mux flop and the model's own flop
	task automatic settle;
		repeat (5) @(posedge mclk_i);
		#1;
	endtask : settle
	task automatic tally_and_finish;
		if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles > 5000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial begin
		void'($urandom(48194));
		repeat (4) @(posedge mclk_i);
		rstn_i <= 1'b1;
		settle();
		check(lines, 7'h0);
		rd(TERM_CTRL_OFF, r);
		check(r, 32'h0);
		for (int i = 0; i < 40; i++) begin
			w = $urandom;
			if (i == 0) w = 32'hffffffff;
			if (i == 1) w = 32'h00000004;
			if (i == 2) w = 32'hfffffffb;
			@(posedge mclk_i);
			hw_next <= 4'($urandom);
			wr(TERM_CTRL_OFF, w);
			// status is read-only, so this must not disturb anything
			wr(TERM_STAT_OFF, ~w);
			settle();
			exp_l = exp_lines(w[7:0], hw_next);
			check(lines, exp_l);
			rd(TERM_CTRL_OFF, r);
			check(r, {24'h0, w[7:0]});
			rd(TERM_STAT_OFF, r);
			check(r, {27'h0, w[2], exp_l[6:3]});
			@(posedge mclk_i);
			#1 check(rdata_o, 32'h0);
		end
		rd(4'hc, r);
		check(r, 32'h0);
		// reset in mid-run with a live control word
		@(posedge mclk_i);
		rstn_i <= 1'b0;
		@(posedge mclk_i);
		rstn_i <= 1'b1;
		settle();
		check(lines, exp_lines(8'h00, hw_next));
		rd(TERM_CTRL_OFF, r);
		check(r, 32'h0);
		tally_and_finish();
	end
endmodule : tb_top
